// ---- logic/plc_pkg.sv ----
// Package for the clock generator register and control block.
// Assumes an AXI4-Lite slave at 32-bit data and one core clock.
// How it works
// [R1] Range multiplier writes are dropped while the loop is on.
// [R2] A zero range multiplier turns the loop off and clears base select.
// [R3] Range multiplier resets to 0x40, a range multiply of sixty-four.
// [R4] Base select cannot be set while the range multiplier is zero.
// [R5] Reference divider writes are dropped while the loop is on.
// [R6] A divider value of zero divides exactly like a value of one.
// [R7] Reference divider resets to one.
// [R8] With auto bandwidth on, lock changes raise the irq when enabled.
// [R9] With auto bandwidth on, the irq flag sets on every lock change regardless of the enable.
// [R10] With auto bandwidth off the irq is blocked and the flag reads zero.
// [R11] Base select may be set while lock is low.
// [R12] Software reads lock after an irq to learn gain or loss.
// [R13] Wait mode changes nothing in this block.
// [R14] Stop with oscillator halt turns everything off, outputs held low.
// [R15] Stop clears base select; after recovery it stays clear.
// [R16] Stop with oscillator running shuts the loop off only.
// [R17] In break with clear enable set, cleared flags stay cleared.
// [R18] In break with clear enable zero, control accesses keep the flag.
// [R19] Outside protected break, reading the control register clears the flag.
// [R20] Base select needs loop on; loop on cannot clear while base select set.
// [R21] Base select low routes oscillator/2, high routes divided VCO/2.
// [R22] Upper divider bits read zero and ignore writes.
package plc_pkg;
  localparam logic [7:0] PLC_OFF_CTRL  = 8'h00;
  localparam logic [7:0] PLC_OFF_BW    = 8'h04;
  localparam logic [7:0] PLC_OFF_RANGE = 8'h08;
  localparam logic [7:0] PLC_OFF_RDIV  = 8'h0C;
  localparam logic [7:0] PLC_OFF_SYS   = 8'h10;
  localparam logic [7:0] PLC_RANGE_RST = 8'h40;
  localparam logic [3:0] PLC_RDIV_RST  = 4'h1;
  // Control register fields
  localparam int PLC_CTRL_IE   = 7;
  localparam int PLC_CTRL_F    = 6;
  localparam int PLC_CTRL_ON   = 5;
  localparam int PLC_CTRL_BCS  = 4;
  // Bandwidth register fields
  localparam int PLC_BW_AUTO   = 7;
  localparam int PLC_BW_LOCK   = 6;
  // System register fields
  localparam int PLC_SYS_BREAK_CLEAR_ENABLE_BIT  = 0;
  localparam int PLC_SYS_XRUN  = 1;
  localparam int PLC_SYS_STOP  = 2;
  localparam int PLC_SYS_BRK   = 3;
  localparam int PLC_SYS_WAIT  = 4;
  localparam logic [1:0] PLC_RESP_OK  = 2'b00;
  localparam logic [1:0] PLC_RESP_ERR = 2'b10;
  typedef struct packed {
    logic        pll_enable;
    logic        osc_enable;
    logic        sel_vco;
    logic        hold_low;
    logic [7:0]  range;
    logic [3:0]  ref_div;
  } plc_ctl_t;
endpackage

// ---- logic/plc_div2.sv ----
// Divide-by-two toggle driven by a one-cycle source enable.
// Assumes the enable comes from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none
module plc_div2 import plc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic tick,
  input  wire logic hold_low,
  output var  logic half_r
);
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      half_r <= 1'b0;
    else if (hold_low)
      half_r <= 1'b0;
    else if (tick)
      half_r <= ~half_r;
  end
endmodule
`default_nettype wire

// ---- logic/plc_top.sv ----
// Register and control logic of the clock generator.
// Assumes pins (lock, osc/vco ticks) come from other domains.
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module plc_top import plc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output var  logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  input  wire logic        lock_in,
  input  wire logic        osc_tick_in,
  input  wire logic        vco_tick_in,
  output var  logic        base_clock_out,
  output var  logic        pll_irq_out,
  output var  logic        vco_clock,
  output var  logic        divided_vco_clock,
  output var  logic        pll_enable_r,
  output var  logic        osc_enable_r,
  output var  logic [7:0]  range_out_r,
  output var  logic [3:0]  ref_div_out_r
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] lock_s, osct_s, vcot_s;
  logic       lock_q, osct_q, vcot_q;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_s <= 2'b00;
      osct_s <= 2'b00;
      vcot_s <= 2'b00;
      lock_q <= 1'b0;
      osct_q <= 1'b0;
      vcot_q <= 1'b0;
    end
    else
    begin
      lock_s <= {lock_s[0], lock_in};
      osct_s <= {osct_s[0], osc_tick_in};
      vcot_s <= {vcot_s[0], vco_tick_in};
      lock_q <= lock_s[1];
      osct_q <= osct_s[1];
      vcot_q <= vcot_s[1];
    end
  end
  // Edge detect only on second stage and its delayed copy
  // Reading the first stage anywhere would let metastability into logic
  wire logic lock_chg = lock_s[1] ^ lock_q;
  wire logic osc_edge = osct_s[1] & ~osct_q;
  wire logic vco_edge = vcot_s[1] & ~vcot_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic       pll_irq_enable_bit_r, pll_irq_flag_r, pll_on_bit_r, base_clock_select_bit_r;
  logic       auto_r, break_clear_enable_bit_r, osc_run_in_stop_bit_r;
  logic       stop_r, break_r, wait_r;
  logic [7:0] vco_range_field_r;
  logic [3:0] ref_div_field_r;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: takes address and data in either order
  logic        aw_have, w_have;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire  logic  wr_go = aw_have & w_have & ~s_axi_bvalid;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_have <= 1'b0;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
        w_have <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_have & ~(s_axi_awvalid & s_axi_awready) & ~wr_go;
      s_axi_wready  <= ~w_have & ~(s_axi_wvalid & s_axi_wready) & ~wr_go;
    end
  end
  function automatic logic known(input logic [7:0] a);
    known = (a == PLC_OFF_CTRL) || (a == PLC_OFF_BW) || (a == PLC_OFF_RANGE) ||
            (a == PLC_OFF_RDIV) || (a == PLC_OFF_SYS);
  endfunction
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PLC_RESP_OK;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known(aw_addr) ? PLC_RESP_OK : PLC_RESP_ERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end
  wire logic we_lo = wr_go & w_strb[0];
  wire logic wr_ctrl  = we_lo & (aw_addr == PLC_OFF_CTRL);
  wire logic wr_bw    = we_lo & (aw_addr == PLC_OFF_BW);
  wire logic wr_range = we_lo & (aw_addr == PLC_OFF_RANGE);
  wire logic wr_rdiv  = we_lo & (aw_addr == PLC_OFF_RDIV);
  wire logic wr_sys   = we_lo & (aw_addr == PLC_OFF_SYS);

  // Read channel
  wire logic rd_go = s_axi_arvalid & s_axi_arready;
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      PLC_OFF_CTRL:  rd_mux[7:0] = {pll_irq_enable_bit_r & auto_r, pll_irq_flag_r & auto_r, // [R10]
                                    pll_on_bit_r, base_clock_select_bit_r, 4'h0};
      PLC_OFF_BW:    rd_mux[7:0] = {auto_r, lock_s[1] & auto_r, 6'h00}; // [R12]
      PLC_OFF_RANGE: rd_mux[7:0] = vco_range_field_r;
      PLC_OFF_RDIV:  rd_mux[7:0] = {4'h0, ref_div_field_r}; // [R22]
      PLC_OFF_SYS:   rd_mux[7:0] = {3'h0, wait_r, break_r, stop_r, osc_run_in_stop_bit_r,
                                    break_clear_enable_bit_r};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= PLC_RESP_OK;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= known(s_axi_araddr) ? PLC_RESP_OK : PLC_RESP_ERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  wire logic rd_ctrl = rd_go & (s_axi_araddr == PLC_OFF_CTRL);

  ////////////////////////////////////////////////////////////////////////
  // System state bits (stop, break, wait) are software visible stand-ins
  // for the mode signals of the integration module.
  logic stop_d;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      break_clear_enable_bit_r <= 1'b0;
      osc_run_in_stop_bit_r    <= 1'b0;
      stop_r                   <= 1'b0;
      break_r                  <= 1'b0;
      wait_r                   <= 1'b0;
      stop_d                   <= 1'b0;
    end
    else
    begin
      stop_d <= stop_r;
      if (wr_sys)
      begin
        break_clear_enable_bit_r <= w_data[PLC_SYS_BREAK_CLEAR_ENABLE_BIT];
        osc_run_in_stop_bit_r    <= w_data[PLC_SYS_XRUN];
        stop_r                   <= w_data[PLC_SYS_STOP];
        break_r                  <= w_data[PLC_SYS_BRK];
        wait_r                   <= w_data[PLC_SYS_WAIT]; // [R13]
      end
    end
  end
  // Stop clears base select on entry only; a later write may set it again
  wire logic stop_enter = stop_r & ~stop_d;
  wire logic protect    = break_r & ~break_clear_enable_bit_r;

  ////////////////////////////////////////////////////////////////////////
  // Control register
  wire logic on_nxt_raw  = w_data[PLC_CTRL_ON];
  wire logic bcs_nxt_raw = w_data[PLC_CTRL_BCS];
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_irq_enable_bit_r    <= 1'b0;
      pll_on_bit_r            <= 1'b1;
      base_clock_select_bit_r <= 1'b0;
    end
    else if (vco_range_field_r == 8'h00)
    begin
      pll_on_bit_r            <= 1'b0; // [R2]
      base_clock_select_bit_r <= 1'b0; // [R2] [R4]
    end
    else if (stop_enter)
      base_clock_select_bit_r <= 1'b0; // [R15]
    else if (wr_ctrl)
    begin
      if (auto_r)
        pll_irq_enable_bit_r <= w_data[PLC_CTRL_IE];
      // Loop can only go off while base select is clear and not being set,
      // so one write never leaves the VCO on the output with the loop off
      if (on_nxt_raw | (~base_clock_select_bit_r & ~bcs_nxt_raw))
        pll_on_bit_r <= on_nxt_raw; // [R20]
      // Lock is not consulted here on purpose
      if (~bcs_nxt_raw | pll_on_bit_r)
        base_clock_select_bit_r <= bcs_nxt_raw; // [R20] [R11]
    end
  end
  // Irq flag: set beats clear; protected break holds it
  // Writes never touch the flag; only a control read clears it
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pll_irq_flag_r <= 1'b0;
    else if (lock_chg & auto_r)
      pll_irq_flag_r <= 1'b1; // [R9]
    else if (rd_ctrl & ~protect)
      pll_irq_flag_r <= 1'b0; // [R19] [R18] [R17]
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      auto_r <= 1'b0;
    else if (wr_bw)
      auto_r <= w_data[PLC_BW_AUTO];
  end

  ////////////////////////////////////////////////////////////////////////
  // Range and divider registers
  // Refused writes still answer OKAY, so software sees no bus error
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      vco_range_field_r <= PLC_RANGE_RST; // [R3]
    else if (wr_range & ~pll_on_bit_r)
      vco_range_field_r <= w_data[7:0]; // [R1]
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ref_div_field_r <= PLC_RDIV_RST; // [R7]
    else if (wr_rdiv & ~pll_on_bit_r)
      ref_div_field_r <= w_data[3:0]; // [R5] [R22]
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to the analog loop and system
  // The analog divider never sees zero; zero is presented as one
  wire logic halt_all = stop_r & ~osc_run_in_stop_bit_r;
  wire logic loop_run = pll_on_bit_r & ~stop_r; // [R16]
  logic osc_half, vco_half;
  plc_div2 u_osc_half
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (osc_edge),
    .hold_low (halt_all),
    .half_r   (osc_half)
  );
  plc_div2 u_vco_half
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tick     (vco_edge),
    .hold_low (~loop_run),
    .half_r   (vco_half)
  );
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      base_clock_out    <= 1'b0;
      pll_irq_out       <= 1'b0;
      vco_clock         <= 1'b0;
      divided_vco_clock <= 1'b0;
      pll_enable_r      <= 1'b0;
      osc_enable_r      <= 1'b1;
      range_out_r       <= PLC_RANGE_RST;
      ref_div_out_r     <= PLC_RDIV_RST;
    end
    else
    begin
      base_clock_out    <= halt_all ? 1'b0 : (base_clock_select_bit_r ? vco_half : osc_half); // [R21] [R14]
      pll_irq_out       <= ~halt_all & auto_r & pll_irq_enable_bit_r & pll_irq_flag_r; // [R8] [R10]
      vco_clock         <= loop_run & vcot_q;
      divided_vco_clock <= loop_run & vcot_q;
      pll_enable_r      <= loop_run; // [R14] [R16]
      osc_enable_r      <= ~halt_all; // [R14]
      range_out_r       <= vco_range_field_r;
      ref_div_out_r     <= (ref_div_field_r == 4'h0) ? 4'h1 : ref_div_field_r; // [R6]
    end
  end
endmodule
`default_nettype wire

// ---- testbench/plc_far_model.sv ----
// Far-side model: oscillator and VCO tick sources and the lock pin.
// Assumes core_clk; both tick rates stay well under half the core rate.
`timescale 1ns/1ps
`default_nettype none
module plc_far_model
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic lock_req,
  output var  logic lock_in,
  output var  logic osc_tick_in,
  output var  logic vco_tick_in
);
  logic [1:0] osc_cnt_r;
  logic [1:0] vco_cnt_r;
  ////////////////////////////////////////////////////////////
  // Osc half period 4 cycles, VCO 3, so the two sources differ
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      osc_cnt_r   <= 2'h0;
      vco_cnt_r   <= 2'h0;
      osc_tick_in <= 1'b0;
      vco_tick_in <= 1'b0;
      lock_in     <= 1'b0;
    end
    else
    begin
      osc_cnt_r   <= osc_cnt_r + 2'h1;
      vco_cnt_r   <= (vco_cnt_r == 2'h2) ? 2'h0 : vco_cnt_r + 2'h1;
      osc_tick_in <= (osc_cnt_r == 2'h3) ? ~osc_tick_in : osc_tick_in;
      vco_tick_in <= (vco_cnt_r == 2'h2) ? ~vco_tick_in : vco_tick_in;
      lock_in     <= lock_req;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/plc_top_chk.sv ----
// Checker for the clock generator block, watching its top ports.
// Assumes one clock and the async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module plc_top_chk import plc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        pll_irq_out,
  input wire logic        base_clock_out,
  input wire logic        vco_clock,
  input wire logic        divided_vco_clock,
  input wire logic        pll_enable_r,
  input wire logic        osc_enable_r,
  input wire logic [7:0]  range_out_r,
  input wire logic [3:0]  ref_div_out_r
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  rst_values_a: assert property ($rose(resetn) |-> range_out_r == PLC_RANGE_RST && ref_div_out_r == PLC_RDIV_RST)
    else $error("settings wrong after reset");
  range_hold_a: assert property (pll_enable_r && $past(pll_enable_r) |-> $stable(range_out_r))
    else $error("range changed while loop on");
  div_hold_a: assert property (pll_enable_r && $past(pll_enable_r) |-> $stable(ref_div_out_r))
    else $error("divider changed while loop on");
  range_nz_a: assert property (pll_enable_r |-> range_out_r != 8'h00)
    else $error("loop on with zero range");
  div_nz_a: assert property (ref_div_out_r != 4'h0)
    else $error("divider presented as zero");
  stop_quiet_a: assert property (!osc_enable_r && !$past(osc_enable_r)
    |-> !base_clock_out && !pll_irq_out && !vco_clock && !divided_vco_clock)
    else $error("output active in halted stop");
  stop_pll_a: assert property (!osc_enable_r && !$past(osc_enable_r) |-> !pll_enable_r)
    else $error("loop on with oscillator halted");
  vco_off_a: assert property ((!pll_enable_r) [*3] |-> !vco_clock && !divided_vco_clock)
    else $error("vco clock with loop off");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  // Cover the main traffic and mode paths
  wr_seen_c: cover property (s_axi_awvalid && s_axi_awready);
  rd_seen_c: cover property (s_axi_arvalid && s_axi_arready);
  irq_seen_c: cover property ($rose(pll_irq_out));
  halt_seen_c: cover property ($fell(osc_enable_r));
endmodule
bind plc_top plc_top_chk u_chk (.core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .pll_irq_out, .base_clock_out, .vco_clock,
  .divided_vco_clock, .pll_enable_r, .osc_enable_r, .range_out_r, .ref_div_out_r);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Testbench: AXI4-Lite register sequences against the clock generator.
// Assumes plc_top, the far model and the checker bind are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import plc_pkg::*;
  logic        core_clk = 1'b0, resetn = 1'b0, lock_req = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, range_out_r;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb = 4'h1, ref_div_out_r;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        lock_in, osc_tick_in, vco_tick_in, base_clock_out, pll_irq_out;
  logic        vco_clock, divided_vco_clock, pll_enable_r, osc_enable_r;
  int          error_cnt = 0, tests_run = 0, n;
  always #2.5 core_clk = ~core_clk;
  plc_top uut (.core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .lock_in, .osc_tick_in, .vco_tick_in, .base_clock_out, .pll_irq_out, .vco_clock,
    .divided_vco_clock, .pll_enable_r, .osc_enable_r, .range_out_r, .ref_div_out_r);
  plc_far_model u_far (.core_clk, .resetn, .lock_req, .lock_in, .osc_tick_in, .vco_tick_in);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge core_clk);
      if (!aw_ok && s_axi_awready === 1'b1)
      begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1)
      begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rdv);
  endtask
  // Lock passes a two-flop sync, so give it time to land
  task automatic tg();
    lock_req <= ~lock_req;
    repeat (12) @(posedge core_clk);
  endtask
  task automatic bcount(input logic v, output int c);
    logic prev;
    logic cur;
    c = 0;
    prev = v ? vco_clock : base_clock_out;
    repeat (240)
    begin
      @(posedge core_clk);
      cur = v ? vco_clock : base_clock_out;
      if (cur === 1'b1 && prev === 1'b0)
        c++;
      prev = cur;
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rc(PLC_OFF_RANGE, 32'h0000_0040);
    rc(PLC_OFF_RDIV, 32'h0000_0001);
    rc(PLC_OFF_CTRL, 32'h0000_0020);
    wr(PLC_OFF_RANGE, 32'h0000_0055);
    rc(PLC_OFF_RANGE, 32'h0000_0040);
    wr(PLC_OFF_RDIV, 32'h0000_0007);
    rc(PLC_OFF_RDIV, 32'h0000_0001);
    wr(PLC_OFF_CTRL, 32'h0000_0000);
    wr(PLC_OFF_CTRL, 32'h0000_0010);
    rc(PLC_OFF_CTRL, 32'h0000_0000);
    wr(PLC_OFF_RANGE, 32'h0000_0033);
    repeat (2) @(posedge core_clk);
    chk("range out", 32'h0000_0033, {24'h00_0000, range_out_r});
    wr(PLC_OFF_RDIV, 32'h0000_00F5);
    rc(PLC_OFF_RDIV, 32'h0000_0005);
    wr(PLC_OFF_RDIV, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("div out", 32'h0000_0001, {28'h000_0000, ref_div_out_r});
    wr(PLC_OFF_RANGE, 32'h0000_0000);
    wr(PLC_OFF_CTRL, 32'h0000_0030);
    rc(PLC_OFF_CTRL, 32'h0000_0000);
    chk("loop run", 32'h0000_0000, {31'h0, pll_enable_r});
    wr(PLC_OFF_RANGE, 32'h0000_0040);
    wr(PLC_OFF_CTRL, 32'h0000_0020);
    wr(PLC_OFF_CTRL, 32'h0000_0010);
    rc(PLC_OFF_CTRL, 32'h0000_0030);
    wr(PLC_OFF_CTRL, 32'h0000_0030);
    rc(PLC_OFF_CTRL, 32'h0000_0030);
    bcount(1'b0, n);
    chk("base on vco", 32'h0000_0001, 32'(n >= 19 && n <= 21));
    bcount(1'b1, n);
    chk("vco run", 32'h0000_0001, 32'(n >= 39 && n <= 41));
    wr(PLC_OFF_CTRL, 32'h0000_0010);
    rc(PLC_OFF_CTRL, 32'h0000_0030);
    tg();
    rc(PLC_OFF_CTRL, 32'h0000_0030);
    chk("irq", 32'h0000_0000, {31'h0, pll_irq_out});
    wr(PLC_OFF_BW, 32'h0000_0080);
    rd(PLC_OFF_CTRL);
    tg();
    chk("irq", 32'h0000_0000, {31'h0, pll_irq_out});
    rc(PLC_OFF_CTRL, 32'h0000_0070);
    rc(PLC_OFF_CTRL, 32'h0000_0030);
    wr(PLC_OFF_CTRL, 32'h0000_00B0);
    tg();
    chk("irq", 32'h0000_0001, {31'h0, pll_irq_out});
    rc(PLC_OFF_BW, 32'h0000_00C0);
    rc(PLC_OFF_CTRL, 32'h0000_00F0);
    repeat (3) @(posedge core_clk);
    chk("irq", 32'h0000_0000, {31'h0, pll_irq_out});
    tg();
    wr(PLC_OFF_SYS, 32'h0000_0008);
    rc(PLC_OFF_CTRL, 32'h0000_00F0);
    rc(PLC_OFF_CTRL, 32'h0000_00F0);
    wr(PLC_OFF_SYS, 32'h0000_0009);
    rc(PLC_OFF_CTRL, 32'h0000_00F0);
    rc(PLC_OFF_CTRL, 32'h0000_00B0);
    wr(PLC_OFF_SYS, 32'h0000_0000);
    rc(PLC_OFF_CTRL, 32'h0000_00B0);
    wr(PLC_OFF_SYS, 32'h0000_0010);
    rc(PLC_OFF_CTRL, 32'h0000_00B0);
    chk("loop run", 32'h0000_0001, {31'h0, pll_enable_r});
    wr(PLC_OFF_SYS, 32'h0000_0006);
    rc(PLC_OFF_CTRL, 32'h0000_00A0);
    chk("loop run", 32'h0000_0000, {31'h0, pll_enable_r});
    chk("osc run", 32'h0000_0001, {31'h0, osc_enable_r});
    bcount(1'b1, n);
    chk("vco stopped", 32'h0000_0000, 32'(n));
    wr(PLC_OFF_SYS, 32'h0000_0002);
    rc(PLC_OFF_CTRL, 32'h0000_00A0);
    bcount(1'b0, n);
    chk("base on osc", 32'h0000_0001, 32'(n >= 14 && n <= 16));
    wr(PLC_OFF_SYS, 32'h0000_0004);
    repeat (2) @(posedge core_clk);
    chk("osc run", 32'h0000_0000, {31'h0, osc_enable_r});
    bcount(1'b0, n);
    chk("base halted", 32'h0000_0000, 32'(n));
    wr(PLC_OFF_SYS, 32'h0000_0000);
    rc(8'h20, 32'h0000_0000);
    chk("rresp", {30'h0, PLC_RESP_ERR}, {30'h0, rsp});
    wr(8'h24, 32'h0000_0001);
    chk("bresp", {30'h0, PLC_RESP_ERR}, {30'h0, rsp});
    tally_and_finish();
  end
endmodule
`default_nettype wire
